// [rtl/brownout_sample_filter_ctrl.sv]
// supply-drop detector control: sampling, deglitch, event flag, APB registers
// assumes comparator level and slow oscillator tick are synchronous to mclk_i
//
// Added by the designer: the APB slave port.
`default_nettype none
// Overview of operation
// - power-up flag set only if enabled, no-reset, low
// - code 00 keeps comparator powered continuously
// - codes 01/10/11 sample every 1.6/6.4/25.6 ms
// - fast clock, code 00, normal mode: 32 system cycles
// - otherwise filter counts 2 slow ticks, bypassed if disabled outside power-down
// - power-down forces 2-tick filtering always
// - filter enable bit, resets to one
// - idle keeps the 32-cycle filter
// - unfiltered sampling gives 16/64/256 tick pulses
// - filtered sampling gives the same 16/64/256 tick pulses
// - control writes need timed unlock
// - flag set on each filtered level change
// - low status is level gated by enable
module brownout_sample_filter_ctrl
#(
  parameter int ADDR_W = 12
)
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic timed_write_unlock_i,
  input wire logic config_detect_enable_i,
  input wire logic config_reset_on_drop_i,
  input wire logic detect_enable_i,
  input wire logic supply_below_i,
  input wire logic slow_tick_i,
  input wire logic fast_clock_source_i,
  input wire logic idle_mode_i,
  input wire logic power_down_i,
  output logic comparator_power_o,
  output logic supply_low_status_o,
  output logic brownout_event_flag_o,
  output logic irq_o
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [1:0] lp_sel;
    logic flt_en;
    logic evt_flag;
    logic evt_mask;
    logic [1:0] init_cnt;
    logic level_seen;
    logic low_status;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ctrl_state_t;

  ctrl_state_t s_q;
  ctrl_state_t s_d;

  logic sampled_level;
  logic filt_level;
  logic comp_pwr;
  logic in_init;
  logic use_sys_count;
  logic flt_bypass;
  logic flt_count_en;
  logic [5:0] flt_limit;
  logic [7:0] word_idx;
  logic hit_ctrl;
  logic hit_status;
  logic hit_mask;
  logic commit;
  logic wr_commit;
  logic evt_set;
  logic evt_clr;
  logic [31:0] rd_word;

  // ****************************************
  // filter clock selection
  // ****************************************
  assign in_init = s_q.init_cnt < bod_pkg::INIT_CYCLES;
  // idle_mode_i does not alter the choice: idle keeps the fast count
  assign use_sys_count = s_q.flt_en && !power_down_i && s_q.lp_sel == 2'h0
    && fast_clock_source_i;
  assign flt_bypass = !s_q.flt_en && !power_down_i;
  assign flt_count_en = use_sys_count ? 1'b1 : slow_tick_i;
  assign flt_limit = use_sys_count ? bod_pkg::FAST_FILTER_CYCLES
    : bod_pkg::SLOW_FILTER_TICKS;

  duty_sampler u_sampler
  (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .mode_i(s_q.lp_sel),
    .slow_tick_i(slow_tick_i),
    .level_i(supply_below_i && detect_enable_i),
    .comp_power_o(comp_pwr),
    .level_o(sampled_level)
  );

  deglitch_filter u_filter
  (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .load_i(in_init),
    .bypass_i(flt_bypass),
    .count_en_i(flt_count_en),
    .limit_i(flt_limit),
    .raw_i(sampled_level),
    .level_o(filt_level)
  );

  // ****************************************
  // APB decode
  // ****************************************
  assign word_idx = paddr_i[9:2];
  assign hit_ctrl = word_idx == bod_pkg::CTRL_IDX;
  assign hit_status = word_idx == bod_pkg::STATUS_IDX;
  assign hit_mask = word_idx == bod_pkg::MASK_IDX;
  // one wait state: pready rises in the second access cycle
  assign commit = psel_i && penable_i && s_q.pready;
  assign wr_commit = commit && pwrite_i;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (hit_ctrl)
    begin
      rd_word[bod_pkg::FLT_BIT] = s_q.flt_en;
      rd_word[bod_pkg::LP_LSB +: 2] = s_q.lp_sel;
    end
    else if (hit_status)
    begin
      rd_word[bod_pkg::EVT_BIT] = s_q.evt_flag;
      rd_word[bod_pkg::LOW_BIT] = s_q.low_status;
    end
    else if (hit_mask)
      rd_word[bod_pkg::EVT_BIT] = s_q.evt_mask;
  end

  // ****************************************
  // next state
  // ****************************************
  assign evt_set = !in_init && filt_level != s_q.level_seen;
  assign evt_clr = wr_commit && hit_status && pwdata_i[bod_pkg::EVT_BIT];

  always_comb
  begin
    s_d = s_q;
    s_d.pready = psel_i && penable_i && !s_q.pready;
    s_d.pslverr = psel_i && penable_i && !s_q.pready
      && !(hit_ctrl || hit_status || hit_mask);
    if (psel_i && penable_i && !s_q.pready)
      s_d.prdata = rd_word;
    if (wr_commit && hit_ctrl && timed_write_unlock_i)
    begin
      s_d.flt_en = pwdata_i[bod_pkg::FLT_BIT];
      s_d.lp_sel = pwdata_i[bod_pkg::LP_LSB +: 2];
    end
    if (wr_commit && hit_mask)
      s_d.evt_mask = pwdata_i[bod_pkg::EVT_BIT];
    if (in_init)
    begin
      s_d.init_cnt = s_q.init_cnt + 2'h1;
      s_d.level_seen = supply_below_i && detect_enable_i;
      // power-up value of the flag from boot options and supply level
      s_d.evt_flag = config_detect_enable_i && !config_reset_on_drop_i
        && supply_below_i;
    end
    else
    begin
      s_d.level_seen = filt_level;
      // a change in the clear cycle still leaves the flag set
      s_d.evt_flag = evt_set || (s_q.evt_flag && !evt_clr);
    end
    s_d.low_status = filt_level && detect_enable_i;
    s_d.irq = s_d.evt_flag && s_d.evt_mask;
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s_q <= '{lp_sel: bod_pkg::LP_RESET, flt_en: bod_pkg::FLT_RESET, evt_flag: 1'b0,
        evt_mask: bod_pkg::MASK_RESET, init_cnt: 2'h0, level_seen: 1'b0,
        low_status: 1'b0, irq: 1'b0, pready: 1'b0, pslverr: 1'b0,
        prdata: 32'h0000_0000};
    end
    else if (ce_i)
      s_q <= s_d;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata_o = s_q.prdata;
  assign pready_o = s_q.pready;
  assign pslverr_o = s_q.pslverr;
  assign comparator_power_o = comp_pwr;
  assign supply_low_status_o = s_q.low_status;
  assign brownout_event_flag_o = s_q.evt_flag;
  assign irq_o = s_q.irq;
endmodule
`default_nettype wire

// [rtl/bod_pkg.sv]
// constants shared by the supply-drop sampling and filter control logic
// assumes a 125 MHz system clock and a slow oscillator tick from outside
`default_nettype none
package bod_pkg;
  // ****************************************
  // register map (printed offsets are word indices)
  // ****************************************
  localparam logic [7:0] CTRL_IDX = 8'hAB;
  localparam logic [7:0] STATUS_IDX = 8'hAC;
  localparam logic [7:0] MASK_IDX = 8'hAD;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int FLT_BIT = 0;
  localparam int LP_LSB = 1;
  localparam int EVT_BIT = 0;
  localparam int LOW_BIT = 1;
  localparam logic [1:0] LP_RESET = 2'h0;
  localparam logic FLT_RESET = 1'b1;
  localparam logic MASK_RESET = 1'b0;

  // ****************************************
  // timing
  // ****************************************
  localparam int SLOW_OSC_PERIOD_US = 100;
  localparam int LP1_PERIOD_US = 1600;
  localparam int LP2_PERIOD_US = 6400;
  localparam int LP3_PERIOD_US = 25600;
  localparam logic [8:0] LP1_TICKS = 9'(LP1_PERIOD_US / SLOW_OSC_PERIOD_US);
  localparam logic [8:0] LP2_TICKS = 9'(LP2_PERIOD_US / SLOW_OSC_PERIOD_US);
  localparam logic [8:0] LP3_TICKS = 9'(LP3_PERIOD_US / SLOW_OSC_PERIOD_US);
  localparam logic [5:0] FAST_FILTER_CYCLES = 6'h20;
  localparam logic [5:0] SLOW_FILTER_TICKS = 6'h02;
  localparam logic [1:0] INIT_CYCLES = 2'h2;
endpackage
`default_nettype wire

// [rtl/duty_sampler.sv]
// periodic or continuous powering of the supply comparator
// assumes slow_tick_i is a one-cycle pulse per slow oscillator period
`default_nettype none
module duty_sampler
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [1:0] mode_i,
  input wire logic slow_tick_i,
  input wire logic level_i,
  output logic comp_power_o,
  output logic level_o
);
  typedef enum logic [2:0] {
    ST_CONT = 3'b001,
    ST_WAIT = 3'b010,
    ST_SENSE = 3'b100
  } samp_state_t;

  typedef struct packed {
    samp_state_t st;
    logic [8:0] cnt;
    logic pwr;
    logic lvl;
  } samp_t;

  samp_t s_q;
  samp_t s_d;
  logic [8:0] period;

  always_comb
  begin
    case (mode_i)
      2'h1: period = bod_pkg::LP1_TICKS;
      2'h2: period = bod_pkg::LP2_TICKS;
      default: period = bod_pkg::LP3_TICKS;
    endcase
  end

  always_comb
  begin
    s_d = s_q;
    case (s_q.st)
      ST_CONT:
      begin
        s_d.pwr = 1'b1;
        s_d.lvl = level_i;
        if (mode_i != 2'h0)
        begin
          s_d.st = ST_WAIT;
          s_d.pwr = 1'b0;
          s_d.cnt = 9'h000;
        end
      end
      ST_WAIT:
      begin
        if (mode_i == 2'h0)
        begin
          s_d.st = ST_CONT;
          s_d.pwr = 1'b1;
        end
        else if (slow_tick_i)
        begin
          // power up one tick ahead so the comparator settles
          if (s_q.cnt >= period - 9'h002)
          begin
            s_d.st = ST_SENSE;
            s_d.pwr = 1'b1;
          end
          s_d.cnt = s_q.cnt + 9'h001;
        end
      end
      ST_SENSE:
      begin
        if (mode_i == 2'h0)
          s_d.st = ST_CONT;
        else if (slow_tick_i)
        begin
          s_d.lvl = level_i;
          s_d.pwr = 1'b0;
          s_d.cnt = 9'h000;
          s_d.st = ST_WAIT;
        end
      end
      default:
      begin
        s_d.st = ST_CONT;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      s_q <= '{st: ST_CONT, cnt: 9'h000, pwr: 1'b1, lvl: 1'b0};
    else if (ce_i)
      s_q <= s_d;
  end

  assign comp_power_o = s_q.pwr;
  assign level_o = s_q.lvl;
endmodule
`default_nettype wire

// [rtl/deglitch_filter.sv]
// counting deglitch filter with selectable count enable and limit
// assumes count_en_i is either always high or a one-cycle tick
`default_nettype none
module deglitch_filter
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic load_i,
  input wire logic bypass_i,
  input wire logic count_en_i,
  input wire logic [5:0] limit_i,
  input wire logic raw_i,
  output logic level_o
);
  typedef struct packed {
    logic pend;
    logic lvl;
    logic [5:0] cnt;
  } flt_t;

  flt_t f_q;
  flt_t f_d;

  always_comb
  begin
    f_d = f_q;
    if (load_i || bypass_i)
    begin
      f_d.pend = raw_i;
      f_d.lvl = raw_i;
      f_d.cnt = 6'h00;
    end
    else if (raw_i != f_q.pend)
    begin
      f_d.pend = raw_i;
      f_d.cnt = 6'h00;
    end
    else if (f_q.pend != f_q.lvl && count_en_i)
    begin
      if (f_q.cnt + 6'h01 >= limit_i)
      begin
        f_d.lvl = f_q.pend;
        f_d.cnt = 6'h00;
      end
      else
        f_d.cnt = f_q.cnt + 6'h01;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      f_q <= '{pend: 1'b0, lvl: 1'b0, cnt: 6'h00};
    else if (ce_i)
      f_q <= f_d;
  end

  assign level_o = f_q.lvl;
endmodule
`default_nettype wire

// [test/brownout_ctrl_asserts.sv]
// port assertions for the supply-drop sampling and filter block
// assumes ce_i is high except for a short final freeze; bound to the top module below
`default_nettype none
module brownout_ctrl_checker
#(
  parameter int ADDR_W = 12
)
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic timed_write_unlock_i,
  input wire logic config_detect_enable_i,
  input wire logic config_reset_on_drop_i,
  input wire logic detect_enable_i,
  input wire logic supply_below_i,
  input wire logic fast_clock_source_i,
  input wire logic power_down_i,
  input wire logic supply_low_status_o,
  input wire logic brownout_event_flag_o,
  input wire logic irq_o
);
  // ****
  // control shadow, since-reset age, run of low samples
  // ****
  logic flt_q;
  logic [1:0] lp_q;
  logic [2:0] age_q;
  logic [5:0] run_q;
  logic fast_on;
  // init edges excluded: the filter is loaded directly there
  assign fast_on = flt_q && fast_clock_source_i && !power_down_i && lp_q == 2'h0
    && age_q == 3'h7;
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      flt_q <= bod_pkg::FLT_RESET;
      lp_q <= bod_pkg::LP_RESET;
      age_q <= 3'h0;
      run_q <= 6'h00;
    end
    else
    begin
      if (psel_i && penable_i && pready_o && pwrite_i && timed_write_unlock_i
        && paddr_i == ADDR_W'({bod_pkg::CTRL_IDX, 2'h0}))
      begin
        flt_q <= pwdata_i[bod_pkg::FLT_BIT];
        lp_q <= pwdata_i[bod_pkg::LP_LSB +: 2];
      end
      if (age_q != 3'h7)
        age_q <= age_q + 3'h1;
      if (supply_below_i && detect_enable_i && !power_down_i && lp_q == 2'h0)
        run_q <= (run_q == 6'h3F) ? run_q : run_q + 6'h01;
      else
        run_q <= 6'h00;
    end
  end
  default clocking dc @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);
  sequence setup_s;
    psel_i && !penable_i;
  endsequence
  sequence access_s;
    psel_i && penable_i;
  endsequence
  apb_wait_a: assert property (setup_s ##1 access_s |=> pready_o)
    else $error("no answer after one wait state");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  irq_flag_a: assert property (irq_o |-> brownout_event_flag_o)
    else $error("interrupt without flag");
  init_flag_a: assert property (age_q == 3'h2 |-> brownout_event_flag_o ==
    (config_detect_enable_i && !config_reset_on_drop_i && $past(supply_below_i)))
    else $error("power-up flag wrong");
  status_gate_a: assert property (!detect_enable_i && !$past(detect_enable_i)
    |-> !supply_low_status_o) else $error("status high while disabled");
  change_flag_a: assert property (age_q == 3'h7 && detect_enable_i &&
    $past(detect_enable_i) && $changed(supply_low_status_o) |-> brownout_event_flag_o)
    else $error("level change without flag");
  fast_min_a: assert property ($rose(supply_low_status_o) && fast_on
    |-> run_q >= 6'h20) else $error("fast filter passed early");
  fast_done_a: assert property (fast_on && run_q == 6'h28 |-> supply_low_status_o)
    else $error("fast filter never passed");
  bypass_a: assert property (!flt_q && run_q == 6'h04 |-> supply_low_status_o)
    else $error("bypass slow");
endmodule
bind brownout_sample_filter_ctrl brownout_ctrl_checker #(.ADDR_W(ADDR_W)) chk_inst (
  .mclk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o,
  .pslverr_o, .timed_write_unlock_i, .config_detect_enable_i, .config_reset_on_drop_i,
  .detect_enable_i, .supply_below_i, .fast_clock_source_i, .power_down_i,
  .supply_low_status_o, .brownout_event_flag_o, .irq_o);
`default_nettype wire

// [test/brownout_sample_filter_ctrl_bench.sv]
// self-checking bench for the supply-drop sampling and filter block
// assumes the checker file binds itself; slow tick every 10 cycles
`default_nettype none
module brownout_sample_filter_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_CTRL = 12'({bod_pkg::CTRL_IDX, 2'h0});
  localparam logic [11:0] A_STAT = 12'({bod_pkg::STATUS_IDX, 2'h0});
  localparam logic [11:0] A_MASK = 12'({bod_pkg::MASK_IDX, 2'h0});
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic unlock = 1'b0;
  logic ce = 1'b1;
  logic cfg_en = 1'b1;
  logic cfg_rst = 1'b0;
  logic det_en = 1'b1;
  logic below = 1'b0;
  logic tick = 1'b0;
  logic fast = 1'b1;
  logic idle = 1'b0;
  logic pd = 1'b0;
  logic comp_pwr;
  logic low_st;
  logic flag;
  logic irq;
  logic [3:0] tick_cnt = 4'h0;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  int n;
  // en, reset-on-drop, below, expected flag
  logic [3:0] rows [5] = '{4'hE, 4'hB, 4'h6, 4'h2, 4'h8};
  brownout_sample_filter_ctrl #(.ADDR_W(12)) brownout_sample_filter_ctrl_inst (
    .mclk_i, .rstn_i, .ce_i(ce), .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .timed_write_unlock_i(unlock),
    .config_detect_enable_i(cfg_en), .config_reset_on_drop_i(cfg_rst),
    .detect_enable_i(det_en), .supply_below_i(below), .slow_tick_i(tick),
    .fast_clock_source_i(fast), .idle_mode_i(idle), .power_down_i(pd),
    .comparator_power_o(comp_pwr), .supply_low_status_o(low_st),
    .brownout_event_flag_o(flag), .irq_o(irq));
  always #4 mclk_i = ~mclk_i;
  always @(posedge mclk_i)
  begin
    tick_cnt <= (tick_cnt == 4'h9) ? 4'h0 : tick_cnt + 4'h1;
    tick <= (tick_cnt == 4'h9);
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      miscompares = miscompares + 1;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // ****
  // bus and wait helpers
  // ****
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do
    begin
      @(posedge mclk_i);
      k++;
    end
    while (pready_o !== 1'b1 && k < 20);
    if (k >= 20)
      miscompares++;
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wait_for(ref logic s, input logic v);
    while (s !== v && n < 6000)
    begin
      @(posedge mclk_i);
      n++;
    end
  endtask
  task automatic drive_low(input logic v);
    below <= v;
    n = 0;
    wait_for(low_st, v);
  endtask
  initial
  begin
    foreach (rows[i])
    begin
      {cfg_en, cfg_rst, below} <= rows[i][3:1];
      rstn_i <= 1'b0;
      repeat (8) @(posedge mclk_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      check("init flag", flag, 32'(rows[i][0]));
    end
    apb(0, A_CTRL, 0);
    check("ctrl reset", rd, 32'h1);
    apb(0, A_MASK, 0);
    check("mask reset", rd, 32'h0);
    apb(1, A_CTRL, 32'hFF);
    apb(0, A_CTRL, 0);
    check("locked write", rd, 32'h1);
    unlock <= 1'b1;
    apb(1, A_CTRL, 32'hFF);
    apb(0, A_CTRL, 0);
    check("reserved bits", rd, 32'h7);
    apb(1, A_CTRL, 32'h1);
    apb(1, A_MASK, 32'h1);
    apb(0, 12'h000, 0);
    check("unmapped", {rd[30:0], err}, 32'h1);
    idle <= 1'b1;
    below <= 1'b1;
    repeat (20) @(posedge mclk_i);
    below <= 1'b0;
    @(posedge mclk_i);
    drive_low(1'b1);
    check("fast filter", 32'(n >= 32 && n <= 38), 32'h1);
    check("rise flag irq", {flag, irq}, 32'h3);
    apb(1, A_STAT, 32'h1);
    apb(0, A_STAT, 0);
    check("cleared flag", rd, 32'h2);
    apb(1, A_MASK, 32'h0);
    drive_low(1'b0);
    check("fall flag irq", {flag, irq}, 32'h2);
    apb(1, A_CTRL, 32'h0);
    drive_low(1'b1);
    check("bypass", 32'(n <= 4), 32'h1);
    pd <= 1'b1;
    drive_low(1'b0);
    check("power-down filter", 32'(n >= 10 && n <= 30), 32'h1);
    pd <= 1'b0;
    fast <= 1'b0;
    apb(1, A_CTRL, 32'h1);
    drive_low(1'b1);
    check("slow filter", 32'(n >= 10 && n <= 30), 32'h1);
    check("always on", comp_pwr, 32'h1);
    for (int m = 1; m < 4; m++)
    begin
      apb(1, A_CTRL, 32'(m << 1));
      n = 0;
      wait_for(comp_pwr, 1'b0);
      wait_for(comp_pwr, 1'b1);
      n = 0;
      wait_for(comp_pwr, 1'b0);
      wait_for(comp_pwr, 1'b1);
      check("sample period", n, 32'(160 << (2 * m - 2)));
    end
    apb(1, A_CTRL, 32'h1);
    det_en <= 1'b0;
    repeat (3) @(posedge mclk_i);
    check("gated status", low_st, 32'h0);
    // frozen: re-enabling detection must not reach the status register
    ce <= 1'b0;
    det_en <= 1'b1;
    repeat (5) @(posedge mclk_i);
    check("frozen status", low_st, 32'h0);
    ce <= 1'b1;
    summarize();
  end
endmodule
`default_nettype wire
